// >>> hw/sibm_top.sv
// shared i2c / spi byte master with its receive buffer
`timescale 1ns/1ps

module sibm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_wr = in_valid_i && in_ready_o;
  wire do_rd = out_valid_o && out_ready_i;

  assign in_ready_o = (count != FULL_COUNT);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sibm_fifo

module sibm_top
  import sibm_pkg::*;
#(
  parameter int RX_DEPTH = 2
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // processor register port
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  // shared serial pins (clock / data)
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // spi only pins
  input wire logic miso_i,
  output logic select_line_zero_o,
  output logic select_line_one_o,
  // received byte stream
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] serial_command;
  logic [7:0] transmit_byte;
  logic [7:0] receive_byte;
  logic [SIBM_FILT_W-1:0] glitch_filter_length;
  logic [SIBM_DIV_W-1:0] serial_clock_divider;
  logic read_ack_value;
  logic target_ack_seen;
  logic abort_flag;
  logic access_direction;
  logic [2:0] bus_phase;

  sibm_state_t state, next_state;
  logic [1:0] ph, next_ph;
  logic [2:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg;
  logic scl_lvl, next_scl;
  logic sda_lvl, next_sda;
  logic cs0, next_cs0;
  logic cs1, next_cs1;
  logic next_abort;
  logic next_ack;
  logic next_dir;
  logic [2:0] next_phase;
  logic [1:0] wr_cnt, next_wrcnt;
  logic push;
  logic fifo_ready;
  logic [SIBM_DIV_W-1:0] div_cnt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire sel_cmd = (bus_addr_i == SIBM_ADDR_CMD);
  wire idle = (state == SIBM_IDLE);
  wire launch = bus_wr_i && sel_cmd && idle;
  wire busy = !idle;
  wire protocol_select = serial_command[SIBM_CMD_PROTO];
  wire new_spi = bus_wdata_i[SIBM_CMD_PROTO];
  wire [2:0] code = serial_command[2:0];
  wire [2:0] new_code = bus_wdata_i[2:0];
  wire spi_read = code[SIBM_SPI_READ];
  wire i2c_read = (code == SIBM_I2C_READ);
  wire is_read = protocol_select ? spi_read : i2c_read;
  wire [SIBM_DIV_W-1:0] div_lim =
    (serial_clock_divider == '0) ? SIBM_DIV_W'(1) : serial_clock_divider;
  // three ticks make one serial clock period
  wire tick = busy && (div_cnt == div_lim - 1'b1);

  // start, stop and release levels {scl, sda} per bit phase
  function automatic logic [1:0] cond_lvl(input logic [2:0] c, input logic [1:0] p);
    logic [1:0] lv;
    lv = 2'b11;
    case (c)
      SIBM_I2C_START: lv = (p == SIBM_BP0) ? 2'b11 : (p == SIBM_BP1) ? 2'b10 : 2'b00;
      SIBM_I2C_STOP: lv = (p == SIBM_BP0) ? 2'b00 : (p == SIBM_BP1) ? 2'b10 : 2'b11;
      SIBM_I2C_REL: lv = (p == SIBM_BP0) ? 2'b01 : 2'b11;
      default: lv = 2'b11;
    endcase
    return lv;
  endfunction

  // ----------------------------------------------------------------
  // input glitch filter
  // ----------------------------------------------------------------
  logic [1:0] raw_in;
  logic [1:0] filt_in;
  assign raw_in = {sda_i, scl_i};
  wire sda_f = filt_in[1];

  genvar gk;
  generate
    for (gk = 0; gk < 2; gk++) begin : g_filt
      logic [SIBM_FILT_W-1:0] fcnt;
      wire differs = (raw_in[gk] != filt_in[gk]);
      // accept once the new level has held for the programmed length
      wire accept = ({1'b0, fcnt} + 1'b1) >= {1'b0, glitch_filter_length};
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          filt_in[gk] <= 1'b1;
          fcnt <= '0;
        end else if (!differs) begin
          fcnt <= '0;
        end else if (accept) begin
          filt_in[gk] <= raw_in[gk];
          fcnt <= '0;
        end else begin
          fcnt <= fcnt + 1'b1;
        end
      end
    end
  endgenerate

  // spi data in bypasses the filter
  wire in_bit = protocol_select ? miso_i : sda_f;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      serial_command <= SIBM_RST_BYTE;
      transmit_byte <= SIBM_RST_BYTE;
      glitch_filter_length <= '0;
      serial_clock_divider <= '0;
      read_ack_value <= 1'b0;
    end else if (bus_wr_i) begin
      if (launch) begin
        serial_command <= bus_wdata_i;
      end
      if (bus_addr_i == SIBM_ADDR_TXD) begin
        transmit_byte <= bus_wdata_i;
      end
      if (bus_addr_i == SIBM_ADDR_FILT) begin
        glitch_filter_length <= bus_wdata_i[SIBM_FILT_W-1:0];
      end
      if (bus_addr_i == SIBM_ADDR_DIVL) begin
        serial_clock_divider[7:0] <= bus_wdata_i;
      end
      if (bus_addr_i == SIBM_ADDR_DIVH) begin
        serial_clock_divider[SIBM_DIV_W-1:8] <= bus_wdata_i[SIBM_DIV_W-9:0];
      end
      if (bus_addr_i == SIBM_ADDR_ACK) begin
        read_ack_value <= bus_wdata_i[0];
      end
    end
  end

  wire [7:0] status = {1'b0, access_direction, bus_phase,
                       target_ack_seen, abort_flag, busy};
  wire [7:0] div_hi = {{(16 - SIBM_DIV_W){1'b0}}, serial_clock_divider[SIBM_DIV_W-1:8]};
  wire [7:0] rd_mux =
    (bus_addr_i == SIBM_ADDR_CMD) ? serial_command :
    (bus_addr_i == SIBM_ADDR_TXD) ? transmit_byte :
    (bus_addr_i == SIBM_ADDR_RXD) ? receive_byte :
    (bus_addr_i == SIBM_ADDR_STAT) ? status :
    (bus_addr_i == SIBM_ADDR_ACK) ? {7'h00, read_ack_value} :
    (bus_addr_i == SIBM_ADDR_FILT) ? {4'h0, glitch_filter_length} :
    (bus_addr_i == SIBM_ADDR_DIVL) ? serial_clock_divider[7:0] :
    (bus_addr_i == SIBM_ADDR_DIVH) ? div_hi : SIBM_UNMAPPED;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      bus_rdata_o <= SIBM_RST_BYTE;
    end else if (bus_rd_i) begin
      bus_rdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // serial clock tick
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !busy || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_ph = ph;
    next_bitn = bitn;
    next_shreg = shreg;
    next_scl = scl_lvl;
    next_sda = sda_lvl;
    next_cs0 = cs0;
    next_cs1 = cs1;
    next_abort = abort_flag;
    next_ack = target_ack_seen;
    next_dir = access_direction;
    next_phase = bus_phase;
    next_wrcnt = wr_cnt;
    push = 1'b0;
    case (state)
      SIBM_IDLE: begin
        if (launch) begin
          next_ph = SIBM_BP0;
          next_bitn = '0;
          next_shreg = transmit_byte;
          if (new_spi) begin
            next_state = SIBM_BITS;
            next_scl = 1'b0;
            next_sda = transmit_byte[7];
            next_cs0 = bus_wdata_i[SIBM_SPI_CS];
            next_cs1 = !bus_wdata_i[SIBM_SPI_CS];
          end else begin
            next_abort = 1'b0;
            case (new_code)
              SIBM_I2C_START, SIBM_I2C_STOP, SIBM_I2C_REL: begin
                next_state = SIBM_COND;
                {next_scl, next_sda} = cond_lvl(new_code, SIBM_BP0);
                if (new_code == SIBM_I2C_START) begin
                  next_wrcnt = '0;
                end
              end
              SIBM_I2C_CTRL, SIBM_I2C_WRITE: begin
                next_state = SIBM_BITS;
                next_scl = 1'b0;
                next_sda = transmit_byte[7];
                next_dir = 1'b1;
                next_phase = (wr_cnt == 2'd0) ? SIBM_PH_SLAVE :
                             (wr_cnt == 2'd1) ? SIBM_PH_START_ADDR : SIBM_PH_DATA;
              end
              SIBM_I2C_READ: begin
                next_state = SIBM_BITS;
                next_scl = 1'b0;
                next_sda = 1'b1;
                next_dir = 1'b0;
                next_phase = SIBM_PH_READ;
              end
              // reserved codes end at once with no bus activity
              default: next_state = SIBM_DONE;
            endcase
          end
        end
      end
      SIBM_COND: begin
        if (tick) begin
          if (ph == SIBM_BP2) begin
            next_state = SIBM_DONE;
          end else begin
            next_ph = ph + 1'b1;
            {next_scl, next_sda} = cond_lvl(code, ph + 1'b1);
          end
        end
      end
      SIBM_BITS: begin
        if (tick) begin
          case (ph)
            SIBM_BP0: begin
              next_ph = SIBM_BP1;
              next_scl = 1'b1;
            end
            SIBM_BP1: begin
              next_ph = SIBM_BP2;
              next_shreg = {shreg[6:0], in_bit};
              if (!protocol_select && code == SIBM_I2C_CTRL && shreg[7] && !sda_f) begin
                next_abort = 1'b1;
                next_sda = 1'b1;
                next_state = SIBM_DONE;
              end
            end
            default: begin
              next_ph = SIBM_BP0;
              next_scl = 1'b0;
              if (bitn != SIBM_LAST_BIT) begin
                next_bitn = bitn + 1'b1;
                next_sda = (!protocol_select && i2c_read) ? 1'b1 : shreg[7];
              end else if (protocol_select) begin
                if (code[SIBM_SPI_LAST]) begin
                  next_cs0 = 1'b1;
                  next_cs1 = 1'b1;
                end
                next_state = spi_read ? SIBM_PUSH : SIBM_DONE;
              end else begin
                next_state = SIBM_ACK;
                next_sda = i2c_read ? read_ack_value : 1'b1;
                if (i2c_read) begin
                  next_phase = SIBM_PH_RDACK;
                end
              end
            end
          endcase
        end
      end
      SIBM_ACK: begin
        if (tick) begin
          case (ph)
            SIBM_BP0: begin
              next_ph = SIBM_BP1;
              next_scl = 1'b1;
            end
            SIBM_BP1: begin
              next_ph = SIBM_BP2;
              if (!i2c_read) begin
                next_ack = sda_f;
              end
            end
            default: begin
              next_ph = SIBM_BP0;
              next_scl = 1'b0;
              next_sda = 1'b1;
              if (!i2c_read && wr_cnt != 2'd2) begin
                next_wrcnt = wr_cnt + 1'b1;
              end
              next_state = i2c_read ? SIBM_PUSH : SIBM_DONE;
            end
          endcase
        end
      end
      SIBM_PUSH: begin
        // a full buffer holds the command busy instead of dropping the byte
        push = 1'b1;
        if (fifo_ready) begin
          next_state = SIBM_DONE;
        end
      end
      SIBM_DONE: begin
        next_state = SIBM_IDLE;
        next_phase = SIBM_PH_IDLE;
      end
      default: next_state = SIBM_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= SIBM_IDLE;
      ph <= SIBM_BP0;
      bitn <= '0;
      shreg <= SIBM_RST_BYTE;
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      cs0 <= 1'b1;
      cs1 <= 1'b1;
      abort_flag <= 1'b0;
      target_ack_seen <= 1'b0;
      access_direction <= 1'b0;
      bus_phase <= SIBM_PH_IDLE;
      wr_cnt <= '0;
      receive_byte <= SIBM_RST_BYTE;
    end else begin
      state <= next_state;
      ph <= next_ph;
      bitn <= next_bitn;
      shreg <= next_shreg;
      scl_lvl <= next_scl;
      sda_lvl <= next_sda;
      cs0 <= next_cs0;
      cs1 <= next_cs1;
      abort_flag <= next_abort;
      target_ack_seen <= next_ack;
      access_direction <= next_dir;
      bus_phase <= next_phase;
      wr_cnt <= next_wrcnt;
      if (push && fifo_ready) begin
        receive_byte <= shreg;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive buffer and pins
  // ----------------------------------------------------------------
  sibm_fifo #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(shreg),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );

  // i2c pulls low only; spi drives both levels
  assign scl_o = protocol_select ? scl_lvl : 1'b0;
  assign scl_oe_n_o = protocol_select ? 1'b0 : scl_lvl;
  assign sda_o = protocol_select ? sda_lvl : 1'b0;
  assign sda_oe_n_o = protocol_select ? 1'b0 : sda_lvl;
  assign select_line_zero_o = cs0;
  assign select_line_one_o = cs1;

endmodule // sibm_top

// >>> hw/sibm_pkg.sv
// shared constants and types for the serial byte master
package sibm_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] SIBM_ADDR_FILT = 16'hf11a;
  localparam logic [15:0] SIBM_ADDR_DIVL = 16'hf11c;
  localparam logic [15:0] SIBM_ADDR_DIVH = 16'hf11d;
  localparam logic [15:0] SIBM_ADDR_CMD = 16'hf11e;
  localparam logic [15:0] SIBM_ADDR_TXD = 16'hf120;
  localparam logic [15:0] SIBM_ADDR_ACK = 16'hf122;
  localparam logic [15:0] SIBM_ADDR_RXD = 16'hf224;
  localparam logic [15:0] SIBM_ADDR_STAT = 16'hf226;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int SIBM_CMD_PROTO = 3;
  localparam int SIBM_CMD_SEL2 = 4;
  localparam int SIBM_SPI_READ = 0;
  localparam int SIBM_SPI_CS = 1;
  localparam int SIBM_SPI_LAST = 2;
  localparam int SIBM_DIV_W = 12;
  localparam int SIBM_FILT_W = 4;
  localparam logic [7:0] SIBM_RST_BYTE = 8'h00;
  localparam logic [7:0] SIBM_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // command codes, bus phases, bit clock phases
  // ----------------------------------------------------------------
  localparam logic [2:0] SIBM_I2C_START = 3'h0;
  localparam logic [2:0] SIBM_I2C_STOP = 3'h1;
  localparam logic [2:0] SIBM_I2C_REL = 3'h2;
  localparam logic [2:0] SIBM_I2C_CTRL = 3'h4;
  localparam logic [2:0] SIBM_I2C_WRITE = 3'h5;
  localparam logic [2:0] SIBM_I2C_READ = 3'h6;
  localparam logic [2:0] SIBM_PH_IDLE = 3'h0;
  localparam logic [2:0] SIBM_PH_SLAVE = 3'h1;
  localparam logic [2:0] SIBM_PH_START_ADDR = 3'h2;
  localparam logic [2:0] SIBM_PH_DATA = 3'h3;
  localparam logic [2:0] SIBM_PH_READ = 3'h4;
  localparam logic [2:0] SIBM_PH_RDACK = 3'h5;
  localparam logic [1:0] SIBM_BP0 = 2'h0;
  localparam logic [1:0] SIBM_BP1 = 2'h1;
  localparam logic [1:0] SIBM_BP2 = 2'h2;
  localparam logic [2:0] SIBM_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    SIBM_IDLE = 3'b000,
    SIBM_BITS = 3'b001,
    SIBM_ACK = 3'b011,
    SIBM_PUSH = 3'b010,
    SIBM_DONE = 3'b110,
    SIBM_COND = 3'b100
  } sibm_state_t;

endpackage

// >>> tb/sibm_properties.sv
// port-level assertion checker for the serial byte master
`timescale 1ns/1ps

module sibm_properties
  import sibm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  // serial pins
  input wire logic scl_o,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o,
  input wire logic select_line_zero_o,
  input wire logic select_line_one_o,
  // receive stream
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] rx_data_o
);
  logic [11:0] div;
  logic [12:0] high_cnt;
  logic [2:0] edge_cnt;
  logic scl_q;
  wire logic idle_sel = select_line_zero_o & select_line_one_o;
  // zero divider behaves as one
  wire logic [12:0] two_n = (div == 12'h000) ? 13'h0002 : {div, 1'b0};
  wire logic div_lo_wr = bus_wr_i && bus_addr_i == SIBM_ADDR_DIVL;
  wire logic div_hi_wr = bus_wr_i && bus_addr_i == SIBM_ADDR_DIVH;

  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      div <= 12'h000;
    end else if (div_lo_wr) begin
      div[7:0] <= bus_wdata_i;
    end else if (div_hi_wr) begin
      div[11:8] <= bus_wdata_i[3:0];
    end
  end
  always_ff @(posedge sys_clk_i) begin
    scl_q <= scl_o;
    high_cnt <= (sys_rst_i || !scl_o) ? 13'h0000 : high_cnt + 13'h0001;
    edge_cnt <= (sys_rst_i || idle_sel) ? 3'h0 : edge_cnt + {2'h0, scl_o & ~scl_q};
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  reset_pins_a: assert property ($fell(sys_rst_i) |-> idle_sel && scl_oe_n_o
    && sda_oe_n_o && !rx_valid_o) else $error("pins not idle after reset");
  divh_upper_a: assert property (bus_rd_i && bus_addr_i == SIBM_ADDR_DIVH
    |=> bus_rdata_o[7:4] == 4'h0) else $error("divider high nibble not zero");
  rdata_hold_a: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
    else $error("read data moved without read");
  select_hot_a: assert property (select_line_zero_o || select_line_one_o)
    else $error("both selects low");
  spi_drive_a: assert property (!idle_sel |-> !scl_oe_n_o && !sda_oe_n_o)
    else $error("spi pins not driven");
  select_launch_a: assert property ($fell(select_line_zero_o) |-> $past(bus_wr_i)
    && $past(bus_addr_i) == SIBM_ADDR_CMD && $past(bus_wdata_i[3]) && !$past(bus_wdata_i[1]))
    else $error("select zero fell without command");
  byte_len_a: assert property ($rose(idle_sel) |-> edge_cnt == 3'h0)
    else $error("frame not whole bytes");
  sck_high_a: assert property ($fell(scl_o) && !idle_sel |-> high_cnt == two_n)
    else $error("serial clock high time wrong");
  rx_stable_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o
    && $stable(rx_data_o)) else $error("stalled byte changed");
endmodule // sibm_properties

bind sibm_top sibm_properties u_props (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .scl_o(scl_o),
  .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o), .select_line_zero_o(select_line_zero_o),
  .select_line_one_o(select_line_one_o), .rx_valid_o(rx_valid_o),
  .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o));

// >>> tb/sibm_partner.sv
// far-side model: spi byte slave and i2c target
`timescale 1ns/1ps

module sibm_partner (
  // spi side
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cs_n_i,
  output logic miso_o,
  // i2c wires
  input wire logic scl_w_i,
  input wire logic sda_w_i,
  output logic sda_pull_o,
  // bench control
  input wire logic [7:0] reply_i,
  input wire logic rd_mode_i,
  output logic [7:0] got_o,
  output logic ack_seen_o
);
  logic [2:0] bit_n = 3'h7;
  logic [3:0] idx = 4'h0;
  // deselected miso shows the inverted bit, never a stale copy
  assign miso_o = reply_i[bit_n] ^ cs_n_i;
  assign sda_pull_o = cs_n_i && (rd_mode_i ? (idx < 4'h8 && !reply_i[3'h7 - idx[2:0]])
                                           : idx == 4'h8);
  always @(negedge cs_n_i) bit_n = 3'h7;
  always @(posedge sck_i) if (!cs_n_i) got_o = {got_o[6:0], mosi_i};
  always @(negedge sck_i) if (!cs_n_i) bit_n = bit_n - 3'h1;
  // start seen: next clock fall begins bit 0
  always @(negedge sda_w_i) if (scl_w_i && cs_n_i) idx = 4'hf;
  always @(negedge scl_w_i) if (cs_n_i) idx = (idx == 4'h8) ? 4'h0 : idx + 4'h1;
  always @(posedge scl_w_i) if (idx == 4'h8) ack_seen_o = sda_w_i;
endmodule // sibm_partner

// >>> tb/testbench.sv
// self-checking bench for the serial byte master
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module testbench import sibm_pkg::*;;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] bus_addr_i = 16'h0000;
  logic bus_wr_i = 1'b0, bus_rd_i = 1'b0, rx_ready_i = 1'b0, rd_chk = 1'b0;
  logic seen = 1'b0, rd_mode = 1'b0;
  logic [7:0] bus_wdata_i = 8'h00, reply = 8'h00, v, r, rx_e;
  logic [7:0] bus_rdata_o, rx_data_o, got, divs [2] = '{8'h00, 8'h03};
  logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, miso, s0, s1, rx_valid_o, pull, ack_seen;
  logic [15:0] addrs [9] = '{SIBM_ADDR_FILT, SIBM_ADDR_DIVL, SIBM_ADDR_DIVH, SIBM_ADDR_CMD,
    SIBM_ADDR_TXD, SIBM_ADDR_ACK, SIBM_ADDR_RXD, SIBM_ADDR_STAT, 16'hf121};
  logic [15:0] exp_q [$];
  logic [7:0] rx_q [$];
  logic [31:0] seed = 32'hb698;
  int failures = 0, comparisons = 0, cycles = 0;
  // open-drain wires with pull-ups
  wire logic scl_w = scl_oe_n_o | scl_o;
  wire logic sda_w = (sda_oe_n_o | sda_o) & ~pull;

  always #2 sys_clk_i = ~sys_clk_i;

  sibm_top dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .miso_i(miso),
    .select_line_zero_o(s0), .select_line_one_o(s1), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o));
  sibm_partner u_partner (.sck_i(scl_o), .mosi_i(sda_o), .cs_n_i(s0 & s1), .miso_o(miso),
    .scl_w_i(scl_w), .sda_w_i(sda_w), .sda_pull_o(pull), .reply_i(reply),
    .rd_mode_i(rd_mode), .got_o(got), .ack_seen_o(ack_seen));

  // ----------------------------------------------------------------
  // bus tasks and checking
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic next_rand;
    seed = lfsr(seed);
    r = seed[7:0] ^ seed[15:8];
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_wr_i = 1'b1;
    @(negedge sys_clk_i);
    bus_wr_i = 1'b0;
  endtask
  // zero mask reads without noting an expectation
  task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge sys_clk_i);
    bus_addr_i = a;
    bus_rd_i = 1'b1;
    rd_chk = (m != 8'h00);
    if (m != 8'h00) exp_q.push_back({m, e & m});
    @(negedge sys_clk_i);
    bus_rd_i = 1'b0;
    v = bus_rdata_o;
  endtask
  // a hung command counts as a mismatch instead of silently timing out
  task automatic wait_idle;
    for (int i = 0; i < 3000; i++) begin
      rd(SIBM_ADDR_STAT, 8'h00, 8'h00);
      if (v[0] === 1'b0) break;
    end
    `CHK("busy cleared", 1'b0, v[0])
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
    wr(SIBM_ADDR_CMD, c);
    rd(SIBM_ADDR_STAT, m, e);
    wait_idle();
  endtask

  always @(posedge sys_clk_i) seen <= bus_rd_i & rd_chk;
  always @(negedge sys_clk_i) begin
    logic [15:0] n;
    if (seen) begin
      n = exp_q.pop_front();
      `CHK("register read", n[7:0], bus_rdata_o & n[15:8])
    end
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (rx_valid_o === 1'b1 && rx_ready_i) begin
      rx_e = rx_q.pop_front();
      `CHK("rx stream", rx_e, rx_data_o)
    end
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'hff, 8'h00);
    wr(SIBM_ADDR_DIVH, 8'hff);
    rd(SIBM_ADDR_DIVH, 8'hff, 8'h0f);
    wr(SIBM_ADDR_FILT, 8'hff);
    rd(SIBM_ADDR_FILT, 8'hff, 8'h0f);
    wr(SIBM_ADDR_ACK, 8'hfe);
    rd(SIBM_ADDR_ACK, 8'hff, 8'h00);
    wr(SIBM_ADDR_STAT, 8'hff);
    rd(SIBM_ADDR_STAT, 8'hff, 8'h00);
    wr(SIBM_ADDR_DIVH, 8'h00);
    wr(SIBM_ADDR_DIVL, 8'h01);
    wr(SIBM_ADDR_FILT, 8'h02);
    // spi write with select held low, select zero in use
    next_rand();
    wr(SIBM_ADDR_TXD, r);
    rd(SIBM_ADDR_TXD, 8'hff, r);
    cmd(8'h18, 8'h01, 8'h01);
    `CHK("mosi byte", r, got)
    `CHK("select held", 1'b0, s0)
    rd(SIBM_ADDR_CMD, 8'h1f, 8'h18);
    // three reads while the consumer stalls; third waits for space
    for (int k = 0; k < 3; k++) begin
      next_rand();
      reply = r;
      rx_q.push_back(r);
      if (k < 2) begin
        cmd(8'h19, 8'h01, 8'h01);
        rd(SIBM_ADDR_RXD, 8'hff, r);
      end
    end
    wr(SIBM_ADDR_CMD, 8'h1d);
    repeat (40) rd(SIBM_ADDR_STAT, 8'h01, 8'h01);
    rx_ready_i = 1'b1;
    wait_idle();
    rd(SIBM_ADDR_RXD, 8'hff, r);
    `CHK("select released", 1'b1, s0)
    // second select at divider zero and three
    foreach (divs[i]) begin
      wr(SIBM_ADDR_DIVL, divs[i]);
      next_rand();
      wr(SIBM_ADDR_TXD, r);
      cmd(8'h1e, 8'h01, 8'h01);
      `CHK("mosi byte cs1", r, got)
      `CHK("select one released", 1'b1, s1)
    end
    // i2c: start, address write, read, reserved, control abort, release, stop
    wr(SIBM_ADDR_DIVL, 8'h02);
    cmd(8'h00, 8'h01, 8'h01);
    wr(SIBM_ADDR_TXD, 8'ha0);
    cmd(8'h05, 8'h39, 8'h09);
    rd(SIBM_ADDR_STAT, 8'hff, 8'h40);
    next_rand();
    reply = r;
    rd_mode = 1'b1;
    rx_q.push_back(r);
    wr(SIBM_ADDR_ACK, 8'h01);
    cmd(8'h06, 8'h39, 8'h21);
    rd(SIBM_ADDR_STAT, 8'h47, 8'h00);
    `CHK("read ack level", 1'b1, ack_seen)
    rd(SIBM_ADDR_RXD, 8'hff, r);
    cmd(8'h03, 8'h01, 8'h00);
    rd(SIBM_ADDR_STAT, 8'h01, 8'h00);
    reply = 8'h7f;
    wr(SIBM_ADDR_TXD, 8'hff);
    cmd(8'h04, 8'h01, 8'h01);
    rd(SIBM_ADDR_STAT, 8'h43, 8'h42);
    rd_mode = 1'b0;
    cmd(8'h02, 8'h01, 8'h01);
    cmd(8'h01, 8'h01, 8'h01);
    give_verdict();
  end
endmodule // testbench
